// ===== ace_consts.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 25 MHz system clock, APB with 32-bit data
// Notes: least times round up to whole cycles
`ifndef ACE_CONSTS_SVH
`define ACE_CONSTS_SVH

`define ACE_OFF_CMD 12'h000
`define ACE_OFF_CTRL 12'h004
`define ACE_OFF_STATUS 12'h008

`define ACE_CMD_W 5
`define ACE_CTRL_W 2
`define ACE_CTRL_RESET 2'h0
`define ACE_STAT_BROWNOUT 6

`define ACE_CLK_NS 40
`define ACE_POR_FAST_NS 4000
`define ACE_POR_STD_NS 50000
`define ACE_RELOAD_PULSE_NS 500
`define ACE_POR_FAST_CYC ((`ACE_POR_FAST_NS + `ACE_CLK_NS - 1) / `ACE_CLK_NS)
`define ACE_POR_STD_CYC ((`ACE_POR_STD_NS + `ACE_CLK_NS - 1) / `ACE_CLK_NS)
`define ACE_RELOAD_CYC \
  ((`ACE_RELOAD_PULSE_NS + `ACE_CLK_NS - 1) / `ACE_CLK_NS)
`define ACE_REVERT_EDGES 10

`define ACE_SEL_ACT_F33 4'hd
`define ACE_SEL_ACT_F30 4'h4
`define ACE_SEL_ACT_S33 4'h2
`define ACE_SEL_ACT_S30 4'h3
`define ACE_SEL_PSER_F 4'hc
`define ACE_SEL_PSER_S 4'h0
`define ACE_SEL_PPAR_F1 4'he
`define ACE_SEL_PPAR_F2 4'hf

`endif

// ===== ace_pkg.sv
// Purpose: shared types of the active configuration clock engage block
// Assumes: nothing beyond the constants header
// Notes: status layout is the word software reads
package ace_pkg;

  typedef enum logic [1:0] {st_por, st_hold, st_config, st_user} ace_state_t;

  typedef enum logic [1:0] {
    sch_none,
    sch_act,
    sch_pser,
    sch_ppar
  } ace_scheme_t;

  typedef struct packed {
    logic dis_ext_clk;
    logic en_ext_clk;
    logic pulse_reload;
    logic disengage;
    logic engage;
  } ace_cmd_t;

  typedef struct packed {
    logic vccio_ok;
    logic vcca_ok;
    logic vccint_ok;
  } ace_supply_t;

  typedef struct packed {
    logic [19:0] rsvd;
    logic ready_pin;
    logic scheme_ppar;
    logic scheme_pser;
    logic scheme_act;
    logic fast_por;
    logic brownout;
    logic pin_disabled;
    logic osc_en;
    logic clk_ext;
    logic ext_latch;
    logic engaged;
    logic user_mode;
  } ace_status_t;

endpackage

// ===== ace_sync.sv
// Purpose: two-flop synchroniser for pins entering the clk domain
// Assumes: bits are independent levels
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module ace_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end

endmodule // ace_sync
`default_nettype wire

// ===== ace_clock_engage.sv
// Purpose: engage, reload and loader clock source control with POR
// Assumes: instructions arrive as APB writes to the command word
// Notes: user clock pin is sampled, so its rate must stay well below clk/2
// How it works
// - engage instruction re-enables the active loader
// - engage in active serial also reconfigures
// - engage in passive schemes acts like pulse
// - after engage the reload pin is ignored
// - loader clock defaults to internal oscillator
// - enable instruction sets external clock latch
// - source switches only while oscillator runs; brown-out reverts it to the oscillator even while the oscillator is stopped
// - oscillator stops once user mode entered
// - user mode keeps oscillator for enabled features
// - disable clears latch, reverts to oscillator
// - without trailing clocks, stays external, pin inert
// - power-on reset clears the external latch
// - pin reload and TAP reset keep latch
// - status pin held low until supplies good
// - core and PLL supplies watched for brown-out
// - scheme pins choose fast or standard delay
// - disengage idles the active loader
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ace_consts.svh"
module ace_clock_engage (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // configuration pins
  input wire logic reload_request_n,
  input wire logic user_supplied_clock_pin,
  input wire logic [3:0] scheme_select_pins,
  input wire ace_pkg::ace_supply_t supply_ok,
  input wire logic loader_ready_n_od_i,
  output logic loader_ready_n_od_o,
  output logic loader_ready_n_od_oe,
  // loader core
  input wire logic config_done,
  output logic loader_run,
  output logic osc_enable,
  output logic clk_src_user
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [9:0] pins_raw;
  logic [9:0] pins_s;
  logic ready_pin_s;
  logic uclk_s;
  logic reload_n_s;
  logic [3:0] sel_s;
  ace_pkg::ace_supply_t sup_s;

  assign pins_raw = {loader_ready_n_od_i, user_supplied_clock_pin,
                     reload_request_n, scheme_select_pins, supply_ok};

  ace_sync #(.W(10)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .din(pins_raw),
    .dout(pins_s)
  );

  assign ready_pin_s = pins_s[9];
  assign uclk_s = pins_s[8];
  assign reload_n_s = pins_s[7];
  assign sel_s = pins_s[6:3];
  assign sup_s = pins_s[2:0];

  ////////////////////////////////////////////////////////////////////////////
  // state

  ace_pkg::ace_state_t state_q, state_d;
  ace_pkg::ace_scheme_t scheme_q;
  logic [15:0] por_cnt_q, por_cnt_d;
  logic [15:0] pulse_cnt_q, pulse_cnt_d;
  logic [3:0] rev_cnt_q;
  logic [`ACE_CTRL_W-1:0] ctrl_q;
  logic engaged_q, pin_dis_q, ext_latch_q, clk_ext_q, osc_en_q;
  logic brownout_q, fast_q, uclk_prev_q, ready_oe_q, run_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  wire setup = psel & ~penable;
  wire wr = psel & penable & pready_q & pwrite;
  wire hit_cmd = (paddr == `ACE_OFF_CMD);
  wire hit_ctrl = (paddr == `ACE_OFF_CTRL);
  wire hit_stat = (paddr == `ACE_OFF_STATUS);
  wire mapped = hit_cmd | hit_ctrl | hit_stat;
  wire ace_pkg::ace_cmd_t cmd = (wr & hit_cmd) ?
      pwdata[`ACE_CMD_W-1:0] : '0;
  wire brown_clr = wr & hit_stat & pwdata[`ACE_STAT_BROWNOUT];

  ////////////////////////////////////////////////////////////////////////////
  // scheme decode

  wire is_act = (sel_s == `ACE_SEL_ACT_F33) | (sel_s == `ACE_SEL_ACT_F30) |
                (sel_s == `ACE_SEL_ACT_S33) | (sel_s == `ACE_SEL_ACT_S30);
  wire is_pser = (sel_s == `ACE_SEL_PSER_F) | (sel_s == `ACE_SEL_PSER_S);
  wire is_ppar = (sel_s == `ACE_SEL_PPAR_F1) | (sel_s == `ACE_SEL_PPAR_F2);
  wire fast_live = (sel_s == `ACE_SEL_ACT_F33) |
                   (sel_s == `ACE_SEL_ACT_F30) |
                   (sel_s == `ACE_SEL_PSER_F) | is_ppar;
  wire ace_pkg::ace_scheme_t scheme_live = is_act ? ace_pkg::sch_act :
      is_pser ? ace_pkg::sch_pser : is_ppar ? ace_pkg::sch_ppar :
      ace_pkg::sch_none;
  // fast or standard delay from the scheme pins
  wire [15:0] por_delay = fast_live ? 16'(`ACE_POR_FAST_CYC) :
                          16'(`ACE_POR_STD_CYC);
  wire scheme_act = (scheme_q == ace_pkg::sch_act);
  wire scheme_pas = (scheme_q == ace_pkg::sch_pser) |
                    (scheme_q == ace_pkg::sch_ppar);

  ////////////////////////////////////////////////////////////////////////////
  // requests

  wire sup_all = sup_s.vccint_ok & sup_s.vcca_ok & sup_s.vccio_ok;
  // core and pll rails keep being watched after power up
  wire brown = (state_q != ace_pkg::st_por) &
               ~(sup_s.vccint_ok & sup_s.vcca_ok);
  // disabled but trailing user clocks missing
  wire stuck = ~ext_latch_q & clk_ext_q;
  // pin is dead after engage or while stuck
  wire pin_req = ~reload_n_s & ~pin_dis_q & ~stuck;
  // engage reconfigures in active and passive schemes, not with no scheme latched; in passive ones it is a pulse
  wire instr_reconf = cmd.pulse_reload |
                      (cmd.engage & (scheme_act | scheme_pas));
  wire in_run = (state_q == ace_pkg::st_config) |
                (state_q == ace_pkg::st_user);
  wire uclk_rise = uclk_s & ~uclk_prev_q;
  wire rev_last = (rev_cnt_q == 4'(`ACE_REVERT_EDGES - 1));
  wire hold_d = (state_d == ace_pkg::st_por) | (state_d == ace_pkg::st_hold);

  ////////////////////////////////////////////////////////////////////////////
  // reset and configuration sequence

  always_comb begin
    state_d = state_q;
    por_cnt_d = por_cnt_q;
    pulse_cnt_d = pulse_cnt_q;
    case (state_q)
      ace_pkg::st_por: begin
        // stay in reset until all rails pass the trip point
        // counts up so the delay follows the pins seen at its end, not
        // the cleared synchroniser just after reset
        if (!sup_all) begin
          por_cnt_d = 16'h0000;
        end else if (por_cnt_q >= por_delay) begin
          state_d = ace_pkg::st_hold;
        end else begin
          por_cnt_d = por_cnt_q + 16'h0001;
        end
      end
      ace_pkg::st_hold: begin
        if (pulse_cnt_q != 16'h0000) begin
          pulse_cnt_d = pulse_cnt_q - 16'h0001;
        end else if (!pin_req) begin
          state_d = ace_pkg::st_config;
        end
      end
      ace_pkg::st_config: begin
        if (config_done) begin
          state_d = ace_pkg::st_user;
        end
      end
      default: begin
        state_d = state_q;
      end
    endcase
    if (brown) begin
      state_d = ace_pkg::st_por;
      por_cnt_d = 16'h0000;
      pulse_cnt_d = 16'h0000;
    end else if (instr_reconf && state_q != ace_pkg::st_por) begin
      state_d = ace_pkg::st_hold;
      pulse_cnt_d = 16'(`ACE_RELOAD_CYC);
    end else if (pin_req && in_run) begin
      // reload through the pin leaves the clock latch alone
      state_d = ace_pkg::st_hold;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= ace_pkg::st_por;
      por_cnt_q <= 16'h0000;
      pulse_cnt_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      por_cnt_q <= por_cnt_d;
      pulse_cnt_q <= pulse_cnt_d;
    end
  end

  // scheme is frozen once the power-on delay ends
  always_ff @(posedge clk) begin
    if (!nrst) begin
      scheme_q <= ace_pkg::sch_none;
      fast_q <= 1'b0;
    end else if (state_q == ace_pkg::st_por) begin
      scheme_q <= scheme_live;
      fast_q <= fast_live;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // engage and disengage

  always_ff @(posedge clk) begin
    if (!nrst) begin
      engaged_q <= 1'b1;
      pin_dis_q <= 1'b0;
    end else begin
      if (cmd.engage) begin
        engaged_q <= 1'b1;
        pin_dis_q <= 1'b1;
      end else if (cmd.disengage && scheme_act) begin
        engaged_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock source latch and selection

  // a power-on reset or brown-out drops the latch
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ext_latch_q <= 1'b0;
    end else if (brown) begin
      ext_latch_q <= 1'b0;
    end else if (cmd.dis_ext_clk) begin
      ext_latch_q <= 1'b0;
    end else if (cmd.en_ext_clk) begin
      ext_latch_q <= 1'b1;
    end
  end

  // except on brown-out, selection moves only just after a user clock rise,
  // so neither source is cut short
  always_ff @(posedge clk) begin
    if (!nrst) begin
      clk_ext_q <= 1'b0;
      rev_cnt_q <= 4'h0;
      uclk_prev_q <= 1'b0;
    end else begin
      uclk_prev_q <= uclk_s;
      if (brown) begin
        clk_ext_q <= 1'b0;
        rev_cnt_q <= 4'h0;
      end else if (ext_latch_q || !clk_ext_q) begin
        rev_cnt_q <= 4'h0;
        if (ext_latch_q && osc_en_q && uclk_rise) begin
          clk_ext_q <= 1'b1;
        end
      end else if (uclk_rise) begin
        if (rev_last && osc_en_q) begin
          clk_ext_q <= 1'b0;
        end else if (!rev_last) begin
          rev_cnt_q <= rev_cnt_q + 4'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // oscillator enable, status pin, loader run

  wire osc_d = (state_d != ace_pkg::st_user) | ctrl_q[0] | ctrl_q[1];

  always_ff @(posedge clk) begin
    if (!nrst) begin
      osc_en_q <= 1'b1;
      ready_oe_q <= 1'b1;
      run_q <= 1'b0;
    end else begin
      osc_en_q <= osc_d;
      ready_oe_q <= hold_d;
      run_q <= engaged_q & (state_d == ace_pkg::st_config);
    end
  end

  // set wins over the software clear
  always_ff @(posedge clk) begin
    if (!nrst) begin
      brownout_q <= 1'b0;
    end else if (brown) begin
      brownout_q <= 1'b1;
    end else if (brown_clr) begin
      brownout_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file

  ace_pkg::ace_status_t status;

  always_comb begin
    status = '0;
    status.ready_pin = ready_pin_s;
    status.scheme_ppar = (scheme_q == ace_pkg::sch_ppar);
    status.scheme_pser = (scheme_q == ace_pkg::sch_pser);
    status.scheme_act = scheme_act;
    status.fast_por = fast_q;
    status.brownout = brownout_q;
    status.pin_disabled = pin_dis_q;
    status.osc_en = osc_en_q;
    status.clk_ext = clk_ext_q;
    status.ext_latch = ext_latch_q;
    status.engaged = engaged_q;
    status.user_mode = (state_q == ace_pkg::st_user);
  end

  wire [31:0] rd_data = hit_stat ? status :
      hit_ctrl ? {30'h0, ctrl_q} : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_q <= `ACE_CTRL_RESET;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup) begin
        prdata_q <= rd_data;
      end
      if (wr && hit_ctrl) begin
        ctrl_q <= pwdata[`ACE_CTRL_W-1:0];
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign loader_ready_n_od_o = 1'b0;
  assign loader_ready_n_od_oe = ready_oe_q;
  assign loader_run = run_q;
  assign osc_enable = osc_en_q;
  assign clk_src_user = clk_ext_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  engage_sets_a: assert property (@(posedge clk) disable iff (!nrst)
    cmd.engage |=> engaged_q && pin_dis_q)
    else $error("engage did not re-enable loader");

  engage_act_a: assert property (@(posedge clk) disable iff (!nrst)
    cmd.engage && scheme_act && !brown && state_q != ace_pkg::st_por
    |=> state_q == ace_pkg::st_hold ##1 loader_ready_n_od_oe)
    else $error("engage in active scheme did not reconfigure");

  engage_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
    cmd.engage && scheme_pas && !brown && state_q != ace_pkg::st_por
    |=> pulse_cnt_q == 16'(`ACE_RELOAD_CYC))
    else $error("engage in passive scheme not a pulse");

  pin_ignored_a: assert property (@(posedge clk) disable iff (!nrst)
    pin_dis_q && state_q == ace_pkg::st_user && !brown && !instr_reconf
    |=> state_q == ace_pkg::st_user)
    else $error("reload pin acted after engage");

  ext_switch_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(clk_ext_q) |-> $past(osc_en_q) && $past(ext_latch_q))
    else $error("clock source changed without oscillator");

  osc_stop_a: assert property (@(posedge clk) disable iff (!nrst)
    state_d == ace_pkg::st_user && ctrl_q == 2'h0 |=> !osc_en_q)
    else $error("oscillator left running in user mode");

  osc_keep_a: assert property (@(posedge clk) disable iff (!nrst)
    ctrl_q != 2'h0 || state_d != ace_pkg::st_user |=> osc_en_q)
    else $error("oscillator stopped while needed");

  revert_edges_a: assert property (@(posedge clk) disable iff (!nrst)
    $fell(clk_ext_q) && !$past(brown)
    |-> $past(rev_cnt_q) == 4'(`ACE_REVERT_EDGES - 1))
    else $error("clock reverted on wrong edge count");

  stuck_pin_a: assert property (@(posedge clk) disable iff (!nrst)
    stuck && state_q == ace_pkg::st_user && !brown && !instr_reconf
    |=> state_q == ace_pkg::st_user)
    else $error("reload pin acted while clock stuck external");

  por_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    state_q == ace_pkg::st_por |-> loader_ready_n_od_oe)
    else $error("status pin released during power-on reset");

  brownout_a: assert property (@(posedge clk) disable iff (!nrst)
    brown |=> state_q == ace_pkg::st_por && !ext_latch_q && brownout_q)
    else $error("brown-out not handled");

endmodule // ace_clock_engage
`default_nettype wire

// ===== ace_instr.sv
// Purpose: test instrument model that drives the user clock pin
// Assumes: run comes from the bench
// Notes: pin finishes the period under way when run falls, then stands low
`timescale 1ns/1ps
`default_nettype none
module ace_instr (
  // control
  input wire logic run,
  // pin
  output logic ucp
);
  // 320 ns period: well under 40 MHz and slow against the sampling clk
  always begin
    if (run) begin
      #160 ucp = 1'b1;
      #160 ucp = 1'b0;
    end else begin
      ucp = 1'b0;
      // steps land on falling clk edges, away from the sampling edge
      #40;
    end
  end
endmodule // ace_instr
`default_nettype wire

// ===== testbench.sv
// Purpose: self-checking bench for ace_clock_engage
// Assumes: inputs other than the user clock pin change by non-blocking assignment at rising clk
// Notes: the open-drain status pin is resolved here with a pull-up
`timescale 1ns/1ps
`default_nettype none
`include "ace_consts.svh"
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rdata;
  logic pready, pslverr, rerr, ucp, od_o, od_oe, od_lvl;
  logic loader_run, osc_enable, clk_src_user;
  logic reload_request_n = 1'b0;
  logic run = 1'b0;
  logic config_done = 1'b0;
  logic [3:0] sel_pins = 4'hd;
  ace_pkg::ace_supply_t supply_ok = 3'h0;
  ace_pkg::ace_status_t st;
  int err_total = 0;
  int checked = 0;
  always #20 clk = ~clk;
  assign od_lvl = od_oe ? od_o : 1'b1;
  ace_clock_engage uut (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reload_request_n(reload_request_n), .user_supplied_clock_pin(ucp),
    .scheme_select_pins(sel_pins), .supply_ok(supply_ok),
    .loader_ready_n_od_i(od_lvl), .loader_ready_n_od_o(od_o),
    .loader_ready_n_od_oe(od_oe), .config_done(config_done),
    .loader_run(loader_run), .osc_enable(osc_enable),
    .clk_src_user(clk_src_user));
  ace_instr tester (.run(run), .ucp(ucp));
  //////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  function automatic logic pick(input int w);
    return w == 0 ? od_oe : (w == 1 ? clk_src_user : loader_run);
  endfunction
  // bounded wait on oe (0), source (1) or loader_run (2)
  task automatic wait_for(input int w, input logic v, input int lim,
                          output int n);
    n = 0;
    while (pick(w) !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) begin
      err_total++;
      $display("[ERR] %0t wait ran out", $time);
      complete_run();
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      err_total++;
      $display("[ERR] %0t apb ready never came", $time);
      complete_run();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic read_status();
    apb(1'b0, `ACE_OFF_STATUS, 32'h0);
    st = rdata;
  endtask
  // holds the pin low long enough, checks oe at the end of the low time
  task automatic pin_pulse(input logic exp_oe);
    reload_request_n <= 1'b0;
    cyc(15);
    chk(od_oe === exp_oe, "reload pin effect");
    reload_request_n <= 1'b1;
    @(posedge clk);
  endtask
  task automatic por(input logic [3:0] sel, input int lo);
    int n;
    nrst <= 1'b0;
    sel_pins <= sel;
    cyc(20);
    chk(od_oe === 1'b1 && osc_enable === 1'b1, "reset outputs");
    chk(clk_src_user === 1'b0, "reset source");
    nrst <= 1'b1;
    wait_for(0, 1'b0, 2000, n);
    chk(n >= lo && n <= lo + 40, "por delay");
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic s_supply();
    cyc(20);
    nrst <= 1'b1;
    cyc(300);
    chk(od_oe === 1'b1, "released while supplies low");
    supply_ok <= 3'h7;
    cyc(200);
    reload_request_n <= 1'b1;
    por(4'hd, 100);
    // pin level reaches the status word through the synchroniser
    cyc(3);
    read_status();
    chk(st.fast_por === 1'b1 && st.scheme_act === 1'b1, "scheme");
    chk(st.ready_pin === 1'b1 && loader_run === 1'b1, "ready pin");
  endtask
  task automatic s_regs();
    apb(1'b0, `ACE_OFF_CTRL, 32'h0);
    chk(rdata === 32'h0 && rerr === 1'b0, "ctrl reset value");
    apb(1'b1, `ACE_OFF_CTRL, 32'h3);
    apb(1'b0, `ACE_OFF_CTRL, 32'h0);
    chk(rdata === 32'h3, "ctrl readback");
    apb(1'b1, `ACE_OFF_CTRL, 32'h0);
    apb(1'b0, `ACE_OFF_CMD, 32'h0);
    chk(rdata === 32'h0, "command reads zero");
    apb(1'b0, 12'h00c, 32'h0);
    chk(rerr === 1'b1 && rdata === 32'h0, "unmapped read");
  endtask
  task automatic s_extclk();
    int n;
    apb(1'b1, `ACE_OFF_CMD, 32'h08);
    run <= 1'b1;
    wait_for(1, 1'b1, 40, n);
    pin_pulse(1'b1);
    wait_for(0, 1'b0, 40, n);
    read_status();
    chk(clk_src_user === 1'b1 && st.ext_latch === 1'b1, "latch kept");
    apb(1'b1, `ACE_OFF_CMD, 32'h10);
    wait_for(1, 1'b0, 150, n);
    chk(n >= 60, "reverted after trailing clocks");
    run <= 1'b0;
  endtask
  task automatic s_user_osc();
    int n;
    config_done <= 1'b1;
    cyc(10);
    read_status();
    chk(st.user_mode === 1'b1 && osc_enable === 1'b0, "osc stopped");
    apb(1'b1, `ACE_OFF_CMD, 32'h08);
    run <= 1'b1;
    cyc(100);
    chk(clk_src_user === 1'b0, "no switch with osc stopped");
    apb(1'b1, `ACE_OFF_CTRL, 32'h1);
    cyc(1);
    chk(osc_enable === 1'b1, "osc for remote update");
    wait_for(1, 1'b1, 40, n);
    apb(1'b1, `ACE_OFF_CTRL, 32'h2);
    chk(osc_enable === 1'b1, "osc for error detect");
    run <= 1'b0;
    cyc(20);
    apb(1'b1, `ACE_OFF_CMD, 32'h10);
    cyc(100);
    chk(clk_src_user === 1'b1, "source stays external");
    pin_pulse(1'b0);
    config_done <= 1'b0;
    por(4'hd, 100);
  endtask
  task automatic s_engage();
    int n;
    apb(1'b1, `ACE_OFF_CMD, 32'h02);
    wait_for(2, 1'b0, 6, n);
    apb(1'b1, `ACE_OFF_CMD, 32'h01);
    wait_for(0, 1'b1, 6, n);
    wait_for(0, 1'b0, 40, n);
    chk(loader_run === 1'b1, "loader engaged again");
    read_status();
    chk(st.pin_disabled === 1'b1, "pin disabled");
    pin_pulse(1'b0);
    por(4'hc, 100);
    read_status();
    chk(st.scheme_pser === 1'b1, "passive scheme latched");
    apb(1'b1, `ACE_OFF_CMD, 32'h04);
    wait_for(0, 1'b1, 6, n);
    wait_for(0, 1'b0, 40, n);
    apb(1'b1, `ACE_OFF_CMD, 32'h01);
    wait_for(0, 1'b1, 6, n);
    wait_for(0, 1'b0, 40, n);
    chk(n >= 8, "engage acts as pulse");
  endtask
  task automatic s_brownout();
    int n;
    supply_ok <= 3'h5;
    wait_for(0, 1'b1, 10, n);
    supply_ok <= 3'h7;
    wait_for(0, 1'b0, 2000, n);
    read_status();
    chk(st.brownout === 1'b1, "brown-out seen");
    apb(1'b1, `ACE_OFF_STATUS, 32'h40);
    read_status();
    chk(st.brownout === 1'b0, "brown-out cleared");
    supply_ok <= 3'h6;
    wait_for(0, 1'b1, 10, n);
    supply_ok <= 3'h7;
    por(4'h2, 1250);
  endtask
  initial begin
    s_supply();
    s_regs();
    s_extclk();
    s_user_osc();
    s_engage();
    s_brownout();
    complete_run();
  end
endmodule // testbench
`default_nettype wire
